//--- rtl/adc_serial_port.sv
// Serial control and result port of a 10-bit sampling converter.
// Assumes the host drives chip select and serial clock far slower than
// clk_i (at least four clk_i periods per serial clock half period).
`timescale 1ns/1ps
`include "adc_port_map.svh"

module adc_serial_port
  import adc_port_pkg::*;
#(
  parameter int RESULT_W = `RESULT_W,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial pins
  input wire logic chip_select_n_i,
  input wire logic sclk_i,
  input wire logic serial_config_in_i,
  output logic serial_result_out_o,
  output logic serial_result_oe_o,
  // Converter side
  output logic power_down_o,
  output logic [1:0] chan_sel_o,
  output logic conv_start_o
);

  if (RESULT_W < 2 || RESULT_W > 16) begin : g_bad_width
    $error("adc_serial_port: bad RESULT_W");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and serial clock edges

  logic [2:0] pins_s;
  logic cs_s;
  logic sclk_s;
  logic din_s;
  logic sclk_d_r;
  logic rise;
  logic fall;

  pin_sync #(
    .WIDTH(3),
    .RST_VAL(3'h1)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({serial_config_in_i, sclk_i, chip_select_n_i}),
    .sync_o(pins_s)
  );

  assign cs_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[2];

  always_ff @(posedge clk_i) begin
    if (rst_i) sclk_d_r <= 1'b0;
    else sclk_d_r <= sclk_s;
  end

  // Edges only count while selected
  assign rise = sclk_s && !sclk_d_r && !cs_s;
  assign fall = !sclk_s && sclk_d_r && !cs_s;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave and result FIFO

  logic mux_en_r;
  logic under_r;
  logic [7:0] conv_cnt_r;
  logic req;
  logic push_req;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [RESULT_W-1:0] fifo_out_data;
  logic pop;
  logic ack_ok;
  logic wr_go;

  function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
    hit = (adr == off);
  endfunction

  assign req = cyc_i && stb_i && !ack_o;
  // Writes commit at the edge where the master samples ack
  assign wr_go = cyc_i && stb_i && ack_o && we_i && sel_i[0];
  assign push_req = req && we_i && hit(adr_i, `ADR_DATA) && sel_i[0];
  // Push holds off ack while the FIFO is full
  assign ack_ok = !push_req || fifo_in_ready;

  sample_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(dat_i[RESULT_W-1:0]),
    .in_valid_i(wr_go && hit(adr_i, `ADR_DATA)),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) ack_o <= 1'b0;
    else ack_o <= req && ack_ok;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (req && ack_ok) begin
      dat_o <= 32'h00000000;
      if (!we_i && hit(adr_i, `ADR_CTRL)) dat_o[`CTRL_MUX_BIT] <= mux_en_r;
      if (!we_i && hit(adr_i, `ADR_STAT)) begin
        dat_o[`STAT_PD_BIT] <= power_down_o;
        dat_o[`STAT_SEL_LSB +: 2] <= chan_sel_o;
        dat_o[`STAT_EMPTY_BIT] <= !fifo_out_valid;
        dat_o[`STAT_FULL_BIT] <= !fifo_in_ready;
        dat_o[`STAT_UNDER_BIT] <= under_r;
        dat_o[`STAT_CNT_LSB +: 8] <= conv_cnt_r;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) mux_en_r <= `CTRL_RST;
    else if (wr_go && hit(adr_i, `ADR_CTRL))
      mux_en_r <= dat_i[`CTRL_MUX_BIT];
  end

  // Underrun is sticky; a new underrun wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) under_r <= 1'b0;
    else if (pop && !fifo_out_valid) under_r <= 1'b1;
    else if (wr_go && hit(adr_i, `ADR_STAT) && dat_i[`STAT_UNDER_BIT])
      under_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial sequencer

  port_state_t state_r;
  logic [1:0] cfg_cnt_r;
  logic [1:0] falls_r;
  logic [3:0] bit_cnt_r;
  logic [RESULT_W-1:0] shift_r;

  // Start conversion: mux mode after the last config bit, fixed at select
  assign pop = conv_start_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_OFF;
      cfg_cnt_r <= 2'h0;
      falls_r <= 2'h0;
      bit_cnt_r <= 4'h0;
    end else if (cs_s) begin
      state_r <= ST_OFF;
    end else begin
      case (state_r)
        ST_OFF: begin
          // Falling select seen: begin the exchange
          if (mux_en_r) state_r <= ST_HUNT;
          else begin
            state_r <= ST_WAIT_EN;
            falls_r <= `FALLS_FIXED;
          end
        end
        ST_HUNT: begin
          if (rise && din_s) begin
            state_r <= ST_CFG;
            cfg_cnt_r <= 2'h0;
          end
        end
        ST_CFG: begin
          if (rise) begin
            cfg_cnt_r <= cfg_cnt_r + 2'h1;
            if (cfg_cnt_r == 2'(`CFG_BITS - 1)) begin
              state_r <= ST_WAIT_EN;
              falls_r <= `FALLS_MUX;
            end
          end
        end
        ST_WAIT_EN: begin
          if (fall) begin
            falls_r <= falls_r - 2'h1;
            if (falls_r == 2'h1) state_r <= ST_NULL;
          end
        end
        ST_NULL: begin
          if (rise) begin
            state_r <= ST_DATA;
            bit_cnt_r <= 4'h0;
          end
        end
        ST_DATA: begin
          if (rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'(RESULT_W - 1)) state_r <= ST_DONE;
          end
        end
        ST_DONE: state_r <= ST_DONE;
        default: state_r <= ST_OFF;
      endcase
    end
  end

  // Input selection; the dummy bit is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) chan_sel_o <= 2'h0;
    else if (!cs_s && state_r == ST_CFG && rise) begin
      if (cfg_cnt_r == 2'h0) chan_sel_o[1] <= din_s;
      if (cfg_cnt_r == 2'h1) chan_sel_o[0] <= din_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) conv_start_o <= 1'b0;
    else conv_start_o <= !cs_s && ((state_r == ST_OFF && !mux_en_r)
                         || (state_r == ST_CFG && rise && cfg_cnt_r == 2'(`CFG_BITS - 1)));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) conv_cnt_r <= 8'h00;
    else if (conv_start_o) conv_cnt_r <= conv_cnt_r + 8'h01;
  end

  // FIFO head loads at the start pulse; empty FIFO gives zero
  always_ff @(posedge clk_i) begin
    if (rst_i) shift_r <= '0;
    else if (conv_start_o) shift_r <= fifo_out_valid ? fifo_out_data : '0;
    else if (state_r == ST_DATA && rise && !cs_s) shift_r <= {shift_r[RESULT_W-2:0], 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////
  // Output pin driver

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_result_oe_o <= 1'b0;
      serial_result_out_o <= 1'b0;
    end else if (cs_s) begin
      serial_result_oe_o <= 1'b0;
      serial_result_out_o <= 1'b0;
    end else begin
      case (state_r)
        ST_WAIT_EN: begin
          if (fall && falls_r == 2'h1) begin
            serial_result_oe_o <= 1'b1;
            serial_result_out_o <= 1'b0;
          end
        end
        ST_NULL: if (rise) serial_result_out_o <= 1'b0;
        ST_DATA: if (rise) serial_result_out_o <= shift_r[RESULT_W-1];
        ST_DONE: if (rise) serial_result_out_o <= 1'b0;
        default: serial_result_oe_o <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) power_down_o <= 1'b1;
    else power_down_o <= cs_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  oe_off_deselect_a: assert property (cs_s |=> !serial_result_oe_o)
    else $error("output enabled while deselected");
  pd_follow_a: assert property (cs_s ##1 cs_s |-> power_down_o)
    else $error("power down not shown while deselected");
  reset_seq_a: assert property (cs_s |=> state_r == ST_OFF)
    else $error("sequencer not reset by chip select");
  hunt_zero_a: assert property (state_r == ST_HUNT && rise && !din_s |=> state_r == ST_HUNT)
    else $error("zero taken as start bit");
  start_bit_a: assert property (state_r == ST_HUNT && rise && din_s |=> state_r == ST_CFG)
    else $error("start bit missed");
  enable_low_a: assert property ($rose(serial_result_oe_o) |-> !serial_result_out_o)
    else $error("output enabled high");
  half_duplex_a: assert property (serial_result_oe_o |-> !(state_r inside {ST_HUNT, ST_CFG}))
    else $error("output driven during config");
  sel_capture_a: assert property (state_r == ST_CFG && cfg_cnt_r == 2'h0 && rise
                                  |=> chan_sel_o[1] == $past(din_s))
    else $error("single-ended select not captured");
  dummy_ignore_a: assert property (state_r == ST_CFG && cfg_cnt_r == 2'h2 && rise
                                   |=> $stable(chan_sel_o))
    else $error("dummy bit altered selection");
  null_bits_a: assert property (state_r == ST_NULL && rise
                                |=> serial_result_oe_o && !serial_result_out_o)
    else $error("second null bit not low");
  msb_first_a: assert property (state_r == ST_DATA && rise
                                |=> serial_result_out_o == $past(shift_r[RESULT_W-1]))
    else $error("result bit order wrong");
  cfg_start_a: assert property (state_r == ST_CFG && cfg_cnt_r == 2'h2 && rise
                                |=> conv_start_o)
    else $error("conversion not started by config");
  fixed_start_a: assert property (state_r == ST_OFF && !cs_s && !mux_en_r
                                  |=> conv_start_o)
    else $error("fixed mode conversion not started");
  enable_fall_a: assert property ($rose(serial_result_oe_o) |-> $past(fall))
    else $error("output enabled away from a falling edge");
  active_power_a: assert property (!cs_s ##1 !cs_s |-> !power_down_o)
    else $error("powered down while selected");
  idle_start_a: assert property (cs_s |=> !conv_start_o)
    else $error("conversion started while deselected");
  select_begin_a: assert property (state_r == ST_OFF && !cs_s |=> state_r != ST_OFF)
    else $error("falling select did not begin exchange");

  mux_exchange_c: cover property (state_r == ST_CFG ##[1:1000] state_r == ST_DONE);
  fixed_exchange_c: cover property (!mux_en_r && state_r == ST_NULL ##[1:1000] state_r == ST_DONE);
  fifo_full_c: cover property (cyc_i && stb_i && !fifo_in_ready);
  abort_c: cover property (state_r == ST_DATA ##1 cs_s);

endmodule

//--- common/adc_port_map.svh
// Register offsets, field positions, reset values and sequence counts
// of the serial conversion port. Included by the package and the RTL.
`ifndef ADC_PORT_MAP_SVH
`define ADC_PORT_MAP_SVH

// Wishbone byte offsets
`define ADR_CTRL 4'h0
`define ADR_DATA 4'h4
`define ADR_STAT 4'h8

// Control fields and reset value
`define CTRL_MUX_BIT 0
`define CTRL_RST 1'b1

// Status fields
`define STAT_PD_BIT 0
`define STAT_SEL_LSB 1
`define STAT_EMPTY_BIT 3
`define STAT_FULL_BIT 4
`define STAT_UNDER_BIT 5
`define STAT_CNT_LSB 8

// Sequence counts
`define RESULT_W 10
`define CFG_BITS 3
`define FALLS_MUX 2'h1
`define FALLS_FIXED 2'h2
`define FIFO_DEPTH 16

`endif

//--- common/adc_port_pkg.sv
// Types shared by the serial conversion port.
// Assumes adc_port_map.svh is on the include path.
`include "adc_port_map.svh"

package adc_port_pkg;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_HUNT,
    ST_CFG,
    ST_WAIT_EN,
    ST_NULL,
    ST_DATA,
    ST_DONE
  } port_state_t;

endpackage

//--- rtl/pin_sync.sv
// Two-flop synchronisers for asynchronous pin inputs.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync: WIDTH must be positive");
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_r;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_r <= RST_VAL[g];
          sync_o[g] <= RST_VAL[g];
        end else begin
          meta_r <= pin_i[g];
          sync_o[g] <= meta_r;
        end
      end
    end
  endgenerate

endmodule

//--- rtl/sample_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/1ps

module sample_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("sample_fifo: bad DEPTH");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("sample_fifo: bad WIDTH");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready_o = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem[rd_ptr_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) mem[wr_ptr_r] <= in_data_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
    end
  end

endmodule

//--- verification/host_model.sv
// Host side of the serial link: chip select, serial clock, config bits.
// Assumes the bench folds the data enable into one shared data line.
`timescale 1ns/1ps

module host_model (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic oe_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o,
  output logic din_en_o,
  output logic [12:0] got_o,
  output logic done_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
    din_en_o = 1'b0;
    got_o = '0;
    done_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Got bit 12 flags a driven line before the enabling fall
  task automatic exchange(input logic mux, input logic [2:0] cfg, input int zeros,
      input int half);
    logic [3:0] word;
    logic [12:0] got;
    int first;
    word = {1'b1, cfg};
    first = mux ? zeros + 4 : 2;
    got = '0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int k = 0; k < first + 12; k++) begin
      // Data moves in the low phase so it is steady at the rise
      din_en_o <= mux && k < zeros + 4;
      din_o <= k >= zeros && word[3 - ((k - zeros) & 3)];
      repeat (half) @(posedge clk_i);
      if (k >= first) got[11:0] = {got[10:0], oe_i ? line_i : 1'bx};
      else if (oe_i) got[12] = 1'b1;
      sclk_o <= 1'b1;
      repeat (half) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    din_en_o <= 1'b0;
    got_o <= got;
    done_o <= 1'b1;
    @(posedge clk_i);
    done_o <= 1'b0;
    cs_n_o <= 1'b1;
  endtask

  // Frame cut short after a few pulses; nothing is sampled
  task automatic cut(input int pulses);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (pulses) begin
      repeat (6) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (6) @(posedge clk_i);
    cs_n_o <= 1'b1;
  endtask

  // Serial clock left running while deselected
  task automatic idle_clocks(input int n);
    repeat (n) begin
      repeat (5) @(posedge clk_i);
      sclk_o <= ~sclk_o;
    end
  endtask
endmodule

//--- verification/adc_serial_port_tb.sv
// Bench for the serial conversion port: bus master, result notes, monitor.
// Assumes host_model on the serial pins, data lines tied together.
`timescale 1ns/1ps
`include "adc_port_map.svh"

module adc_serial_port_tb;
  logic clk_i, rst_i, cyc, stb, we, ack, cs_n, sclk, din, din_en, line, out, oe, pd, done;
  logic start;
  logic flip = 1'b0;
  logic [3:0] adr, sel;
  logic [31:0] dat, rdat, q;
  logic [1:0] chan_sel;
  logic [12:0] got;
  logic [16:0] note;
  logic [15:0] seed = 16'h0019;
  logic [9:0] dq[$];
  logic [16:0] notes[$];
  int n_fail = 0;
  int checks_done = 0;
  int n_start = 0;

  adc_serial_port DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .chip_select_n_i(cs_n), .sclk_i(sclk), .serial_config_in_i(line),
    .serial_result_out_o(out), .serial_result_oe_o(oe), .power_down_o(pd),
    .chan_sel_o(chan_sel), .conv_start_o(start));

  host_model host (.clk_i(clk_i), .line_i(line), .oe_i(oe), .cs_n_o(cs_n), .sclk_o(sclk),
    .din_o(din), .din_en_o(din_en), .got_o(got), .done_o(done));

  // Released line toggles so a stale value cannot pass
  assign line = oe ? out : (din_en ? din : flip);
  always @(posedge clk_i) flip <= ~flip;
  always @(posedge clk_i) if (start === 1'b1) n_start++;

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int t;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 2000);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (t >= 2000) begin
      n_fail++;
      close_out();
    end
  endtask

  // Note: mux flag, power down, select, early drive, nulls, data
  task automatic xfer(input logic mux, input logic [2:0] cfg, input int zeros);
    logic [9:0] d;
    d = dq.size() > 0 ? dq.pop_front() : 10'h000;
    seed = lfsr(seed);
    notes.push_back({mux, 1'b0, cfg[2:1], 3'b000, d});
    host.exchange(mux, cfg, zeros, 5 + int'(seed[1:0]));
    repeat (8) @(posedge clk_i);
    check("idle pins", 32'({pd, oe}), 32'h2);
  endtask

  task automatic push();
    seed = lfsr(seed);
    dq.push_back(seed[9:0]);
    wb(1'b1, `ADR_DATA, {22'h0, seed[9:0]}, 4'hF);
  endtask

  always @(posedge clk_i) begin
    if (done === 1'b1) begin
      note = notes.pop_front();
      check("frame", 32'({note[16], pd, note[16] ? chan_sel : note[14:13], got}),
        32'(note));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'hF;
    dat = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, `ADR_CTRL, 32'h0, 4'hF);
    check("ctrl reset", q, 32'h1);
    wb(1'b0, `ADR_STAT, 32'h0, 4'hF);
    check("stat reset", 32'(q[15:0]), 32'h9);
    wb(1'b0, 4'hC, 32'h0, 4'hF);
    check("unmapped", q, 32'h0);
    wb(1'b1, `ADR_CTRL, 32'h0, 4'hE);
    wb(1'b0, `ADR_CTRL, 32'h0, 4'hF);
    check("ctrl masked", q, 32'h1);
    // Empty buffer gives a zero result and a sticky flag
    xfer(1'b1, 3'b101, 2);
    wb(1'b0, `ADR_STAT, 32'h0, 4'hF);
    check("underrun", 32'({q[15:8], q[5], q[3], q[0]}), 32'h00F);
    wb(1'b1, `ADR_STAT, 32'h20, 4'hF);
    wb(1'b0, `ADR_STAT, 32'h0, 4'hF);
    check("underrun clear", 32'(q[5]), 32'h0);
    repeat (16) push();
    wb(1'b0, `ADR_STAT, 32'h0, 4'hF);
    check("fifo full", 32'(q[4:3]), 32'h2);
    // Push into a full buffer stalls until the frame pops
    fork
      push();
      xfer(1'b1, 3'b100, 0);
    join
    for (int i = 1; i <= 16; i++) xfer(1'b1, {i[1:0], seed[3]}, i % 3);
    wb(1'b0, `ADR_STAT, 32'h0, 4'hF);
    check("drained", 32'({q[15:8], q[4:3]}), {22'h0, 8'd18, 2'b01});
    wb(1'b1, `ADR_CTRL, 32'h0, 4'hF);
    push();
    push();
    xfer(1'b0, 3'b000, 0);
    xfer(1'b0, 3'b000, 0);
    // Cut frame pops an empty buffer; the next frame must still work
    host.cut(4);
    repeat (8) @(posedge clk_i);
    check("cut idle", 32'({pd, oe}), 32'h2);
    push();
    xfer(1'b0, 3'b000, 0);
    host.idle_clocks(20);
    wb(1'b0, `ADR_STAT, 32'h0, 4'hF);
    check("idle clocks", 32'({q[15:8], q[0]}), {23'h0, 8'h16, 1'b1});
    check("starts", n_start, 32'h16);
    check("notes left", notes.size(), 32'h0);
    close_out();
  end
endmodule
